// ==== spi_eeprom_select_output_control.sv ====
// Function
// (R01) low select selects, traffic only while low
// (R02) select high gives standby unless writing
// (R03) started write cycle always runs to end
// (R04) standby entered only after write cycle ends
// (R05) serial output high impedance when deselected
// (R06) select rise after valid write launches cycle
// (R07) ignore everything until first select fall
// (R08) output bits change after serial clock fall
// (R09) input bits captured on serial clock rise
// (R10) bytes travel most significant bit first
// (R11) pause low puts serial output high impedance
// (R12) select rise off byte boundary abandons write
// (R13) select fall clears the bit counter
// (R14) deselected: clock and data are ignored
`timescale 1ns/1ps

module spi_eeprom_select_output_control #(
  parameter int TWC_CYCLES = spi_sel_pkg::TWC_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic pause_n_pin,
  input wire logic write_armed,
  input wire logic tx_active,
  input wire logic [spi_sel_pkg::BYTE_BITS-1:0] tx_byte,
  output logic so_out,
  output logic so_oe_n,
  output logic selected,
  output logic standby,
  output logic paused,
  output logic write_busy,
  output logic write_abandon,
  output logic [spi_sel_pkg::BYTE_BITS-1:0] rx_byte,
  output logic rx_byte_valid,
  output logic tx_byte_req,
  output logic [spi_sel_pkg::BIT_CNT_W-1:0] bit_count
);

  localparam int BB = spi_sel_pkg::BYTE_BITS;
  localparam int IW = spi_sel_pkg::BIT_IDX_W;
  localparam int CW = spi_sel_pkg::BIT_CNT_W;
  localparam int NL = spi_sel_pkg::LANES;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NL-1:0] pins;
  logic [NL-1:0] meta_reg;
  logic [NL-1:0] sync_reg;
  logic [NL-1:0] prev_reg;

  assign pins[spi_sel_pkg::LANE_CS] = cs_n_pin;
  assign pins[spi_sel_pkg::LANE_SCK] = sck_pin;
  assign pins[spi_sel_pkg::LANE_SI] = si_pin;
  assign pins[spi_sel_pkg::LANE_PAUSE] = pause_n_pin;

  // two flops per lane, then one more for edge finding
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_sync
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          meta_reg[g] <= spi_sel_pkg::LANE_IDLE[g];
          sync_reg[g] <= spi_sel_pkg::LANE_IDLE[g];
          prev_reg[g] <= spi_sel_pkg::LANE_IDLE[g];
        end else begin
          meta_reg[g] <= pins[g];
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
        end
      end
    end
  endgenerate

  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic pause_n_s;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  assign cs_n_s = sync_reg[spi_sel_pkg::LANE_CS];
  assign sck_s = sync_reg[spi_sel_pkg::LANE_SCK];
  assign si_s = sync_reg[spi_sel_pkg::LANE_SI];
  assign pause_n_s = sync_reg[spi_sel_pkg::LANE_PAUSE];
  assign cs_fall = prev_reg[spi_sel_pkg::LANE_CS] && !cs_n_s;
  assign cs_rise = !prev_reg[spi_sel_pkg::LANE_CS] && cs_n_s;
  assign sck_rise = !prev_reg[spi_sel_pkg::LANE_SCK] && sck_s;
  assign sck_fall = prev_reg[spi_sel_pkg::LANE_SCK] && !sck_s;

  // ----------------------------------------------------------------
  // power-up arming and selection
  // ----------------------------------------------------------------
  logic armed_reg;
  logic sel_reg;
  logic paused_reg;
  logic active;

  // a select that is already low at power-up does not count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      armed_reg <= 1'b0;
    end else if (cs_fall) begin
      armed_reg <= 1'b1; // R07
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_reg <= 1'b0;
    end else begin
      sel_reg <= !cs_n_s && (armed_reg || cs_fall); // R01 R07
    end
  end

  // the pause flag sets only while the clock is low, and clears with a low clock or on deselect
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      paused_reg <= 1'b0;
    end else if (!sel_reg) begin
      paused_reg <= 1'b0;
    end else if (!sck_s) begin
      paused_reg <= !pause_n_s;
    end
  end

  // bit traffic is honoured only while selected and not paused
  assign active = sel_reg && !cs_n_s && !paused_reg; // R01 R14

  // ----------------------------------------------------------------
  // bit counter and receive shifter
  // ----------------------------------------------------------------
  logic [CW-1:0] bit_cnt_reg;
  logic [BB-1:0] rx_shift_reg;
  logic [BB-1:0] rx_byte_reg;
  logic rx_valid_reg;
  logic [IW-1:0] bit_idx;

  assign bit_idx = bit_cnt_reg[IW-1:0];

  // select fall or deselect drops any half-received frame
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_reg <= spi_sel_pkg::BIT_CNT_RESET;
    end else if (cs_fall || !sel_reg) begin
      bit_cnt_reg <= spi_sel_pkg::BIT_CNT_RESET; // R13 R14
    end else if (active && sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + CW'(1);
    end
  end

  // first bit lands at the top so the byte fills msb first
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_shift_reg <= spi_sel_pkg::BYTE_RESET;
      rx_byte_reg <= spi_sel_pkg::BYTE_RESET;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (cs_fall || !sel_reg) begin
        rx_shift_reg <= spi_sel_pkg::BYTE_RESET; // R14
      end else if (active && sck_rise) begin
        rx_shift_reg <= {rx_shift_reg[BB-2:0], si_s}; // R09 R10
        if (bit_idx == IW'(BB - 1)) begin
          rx_byte_reg <= {rx_shift_reg[BB-2:0], si_s};
          rx_valid_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  logic [BB-1:0] tx_shift_reg;
  logic so_reg;
  logic so_oe_n_reg;
  logic tx_req_reg;

  // the decoder sees the request a cycle after tx_byte is taken, a byte before the next load
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_shift_reg <= spi_sel_pkg::BYTE_RESET;
      so_reg <= 1'b0;
      tx_req_reg <= 1'b0;
    end else begin
      tx_req_reg <= 1'b0;
      if (active && tx_active && sck_fall) begin
        if (bit_idx == spi_sel_pkg::BIT_IDX_FIRST) begin
          so_reg <= tx_byte[BB-1]; // R08 R10
          tx_shift_reg <= {tx_byte[BB-2:0], 1'b0};
          tx_req_reg <= 1'b1;
        end else begin
          so_reg <= tx_shift_reg[BB-1]; // R08 R10
          tx_shift_reg <= {tx_shift_reg[BB-2:0], 1'b0};
        end
      end
    end
  end

  // pause low floats the line at once, without waiting for the clock
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      so_oe_n_reg <= 1'b1;
    end else begin
      so_oe_n_reg <= !(active && tx_active && pause_n_s); // R05 R11
    end
  end

  // ----------------------------------------------------------------
  // write cycle launch and standby
  // ----------------------------------------------------------------
  write_timer_if wt ();
  logic start_reg;
  logic abandon_reg;
  logic standby_reg;
  logic on_boundary;

  assign on_boundary = (bit_idx == spi_sel_pkg::BIT_IDX_FIRST) &&
                       (bit_cnt_reg != spi_sel_pkg::BIT_CNT_RESET);

  // a rise mid-byte throws the write away rather than half-writing it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      start_reg <= 1'b0;
      abandon_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      abandon_reg <= 1'b0;
      if (cs_rise && sel_reg && write_armed && !wt.busy) begin
        if (on_boundary) begin
          start_reg <= 1'b1; // R06 R12
        end else begin
          abandon_reg <= 1'b1; // R12
        end
      end
    end
  end

  assign wt.start = start_reg;

  write_timer #(
    .TWC_CYCLES(TWC_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .resetn(resetn),
    .wt(wt)
  );

  // standby waits out a running write whatever select does meanwhile
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      standby_reg <= 1'b1;
    end else begin
      standby_reg <= !sel_reg && !wt.busy && !start_reg; // R02 R03 R04
    end
  end

  assign so_out = so_reg;
  assign so_oe_n = so_oe_n_reg;
  assign selected = sel_reg;
  assign standby = standby_reg;
  assign paused = paused_reg;
  assign write_busy = wt.busy;
  assign write_abandon = abandon_reg;
  assign rx_byte = rx_byte_reg;
  assign rx_byte_valid = rx_valid_reg;
  assign tx_byte_req = tx_req_reg;
  assign bit_count = bit_cnt_reg;

endmodule

// ==== spi_master_model.sv ====
`timescale 1ns/1ps
// ----------
// host side: select, serial clock and data in
// ----------
module spi_master_model (
  output logic cs_n_pin,
  output logic sck_pin,
  output logic si_pin,
  input wire logic so_line
);
  // select low from power-up, so the first frame must be refused
  initial begin
    cs_n_pin = 1'b0;
    sck_pin = 1'b0;
    si_pin = 1'b0;
  end
  // sel puts the select fall off the system clock grid, xfer keeps its caller's phase; link clock idles low
  task automatic sel();
    #437 cs_n_pin = 1'b0;
    #500;
  endtask
  task automatic desel();
    cs_n_pin = 1'b1;
    si_pin = ~si_pin; // released line no longer shows the last bit
  endtask
  // n bits msb first; device output taken just before each rise
  task automatic xfer(input logic [7:0] b, input int n,
    output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si_pin = b[i];
      #500 r[i] = so_line;
      sck_pin = 1'b1;
      #300 sck_pin = 1'b0;
    end
  endtask
endmodule

// ==== spi_sel_checker.sv ====
`timescale 1ns/1ps
// ----------
// select, standby and output checks
// ----------
module spi_sel_checker #(
  parameter int TWC_CYCLES = spi_sel_pkg::TWC_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cs_n_pin,
  input wire logic pause_n_pin,
  input wire logic write_armed,
  input wire logic so_oe_n,
  input wire logic selected,
  input wire logic standby,
  input wire logic write_busy,
  input wire logic rx_byte_valid,
  input wire logic [15:0] bit_count
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [15:0] busy_len;
  logic [15:0] frame_bits;
  // length of the running write cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_len <= 16'h0000;
    end else begin
      busy_len <= write_busy ? busy_len + 16'h0001 : 16'h0000;
    end
  end
  // bits of the frame just closed; bit_count clears once deselected
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frame_bits <= 16'h0000;
    end else if (selected) begin
      frame_bits <= bit_count;
    end
  end
  sequence s_good_rise;
    $fell(selected) && write_armed && frame_bits != 16'h0000 &&
      frame_bits[2:0] == 3'h0;
  endsequence
  sequence s_bad_rise;
    $fell(selected) && write_armed && frame_bits[2:0] != 3'h0;
  endsequence
  sequence s_no_launch;
    !write_busy [*4];
  endsequence
  chk_launch_write: assert property (
    s_good_rise |-> ##[1:3] write_busy) else $error("write not launched");
  chk_abandon_quiet: assert property (
    s_bad_rise |-> s_no_launch) else $error("partial frame launched");
  chk_busy_length: assert property (
    $fell(write_busy) |-> busy_len >= TWC_CYCLES - 1 &&
      busy_len <= TWC_CYCLES + 1) else $error("write cycle length");
  chk_busy_standby: assert property (
    write_busy |-> !standby) else $error("standby while writing");
  chk_standby_after: assert property (
    $fell(write_busy) && cs_n_pin |-> ##[1:2] standby)
    else $error("no standby after write");
  chk_desel_hiz: assert property (
    !selected [*3] |-> so_oe_n) else $error("output driven deselected");
  chk_pause_hiz: assert property (
    !pause_n_pin [*5] |-> so_oe_n) else $error("output driven paused");
  chk_select_high: assert property (
    cs_n_pin [*5] |-> !selected) else $error("selected with select high");
  chk_count_clear: assert property (
    $rose(selected) |-> bit_count == 16'h0000) else $error("count kept");
  chk_byte_bound: assert property (
    rx_byte_valid |-> bit_count[2:0] == 3'h0 && bit_count != 16'h0000)
    else $error("byte off boundary");
endmodule
bind spi_eeprom_select_output_control spi_sel_checker #(
  .TWC_CYCLES(TWC_CYCLES)
) i_chk (
  .mclk(mclk),
  .resetn(resetn),
  .cs_n_pin(cs_n_pin),
  .pause_n_pin(pause_n_pin),
  .write_armed(write_armed),
  .so_oe_n(so_oe_n),
  .selected(selected),
  .standby(standby),
  .write_busy(write_busy),
  .rx_byte_valid(rx_byte_valid),
  .bit_count(bit_count)
);

// ==== spi_sel_pkg.sv ====
package spi_sel_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int MCLK_HZ = 10_000_000;
  localparam int TWC_MS = 5; // longest internal write cycle, in ms
  localparam int MS_PER_S = 1000;
  localparam int TWC_CYCLES = (TWC_MS * MCLK_HZ) / MS_PER_S;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int BIT_IDX_W = 3; // bit position inside a byte
  localparam int BIT_CNT_W = 16; // bits seen in one frame
  localparam int SYNC_STAGES = 2;
  localparam logic [BIT_IDX_W-1:0] BIT_IDX_FIRST = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 16'h0000;
  localparam logic [BYTE_BITS-1:0] BYTE_RESET = 8'h00;

  // pin synchroniser lanes
  localparam int LANE_CS = 0;
  localparam int LANE_SCK = 1;
  localparam int LANE_SI = 2;
  localparam int LANE_PAUSE = 3;
  localparam int LANES = 4;
  // select resets to its low level, so a select already low at power-up
  // shows no falling edge and cannot arm the port; the clock idles low
  localparam logic [LANES-1:0] LANE_IDLE = 4'h8;

endpackage

// ==== tb_spi_eeprom_select_output_control.sv ====
`timescale 1ns/1ps
module tb_spi_eeprom_select_output_control;
  logic mclk = 0, resetn = 0, pause_n_pin = 1;
  logic write_armed = 0, tx_active = 0;
  logic [7:0] tx_byte = 8'ha5, rx_byte, r;
  logic so_out, so_oe_n, selected, standby, paused, write_busy;
  logic write_abandon, rx_byte_valid, tx_byte_req;
  logic [15:0] bit_count;
  wire cs_n_pin, sck_pin, si_pin;
  wire so_line = so_oe_n ? 1'bz : so_out;
  int failures = 0, checks_done = 0;
  int reqs = 0;
  // short write cycle keeps the run brief
  spi_eeprom_select_output_control #(.TWC_CYCLES(60)) i_dut (.*);
  spi_master_model i_mst (.*);
  // byte requests counted on the falling edge, clear of the launching edge
  always @(negedge mclk) if (tx_byte_req === 1'b1) reqs++;
  // ----------
  // compare, bounded wait and verdict
  // ----------
  task automatic chk(string n, logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // sampled on the falling edge so a one-cycle pulse is seen while it stands
  task automatic wt(input bit ab, input logic v, input int n);
    logic s;
    s = ~v;
    for (int k = 0; k < n && s !== v; k++) begin
      @(negedge mclk);
      s = ab ? write_abandon : write_busy;
    end
    chk("wait", s, v);
    if (s !== v) close_out();
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_power_up();
    i_mst.xfer(8'h81, 8, r);
    chk("selected", selected, 1'b0);
    chk("rx_byte", rx_byte, 8'h00);
    i_mst.desel();
  endtask
  task automatic t_read();
    @(posedge mclk) tx_active <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("so_oe_n", so_oe_n, 1'b1);
    i_mst.sel();
    i_mst.xfer(8'h03, 8, r);
    chk("rx_byte", rx_byte, 8'h03);
    chk("bit_count", bit_count, 16'h0008);
    i_mst.xfer(8'h00, 8, r);
    chk("so_data", r, 8'ha5);
    chk("so_oe_n", so_oe_n, 1'b0);
    @(posedge mclk) pause_n_pin <= 1'b0;
    repeat (6) @(negedge mclk);
    chk("so_oe_n", so_oe_n, 1'b1);
    chk("paused", paused, 1'b1);
    @(posedge mclk) pause_n_pin <= 1'b1;
    repeat (6) @(negedge mclk);
    chk("so_oe_n", so_oe_n, 1'b0);
    i_mst.desel();
    repeat (6) @(negedge mclk);
    chk("so_oe_n", so_oe_n, 1'b1);
    chk("standby", standby, 1'b1);
    chk("tx_byte_req", 16'(reqs), 16'h0002);
    @(posedge mclk) tx_active <= 1'b0;
  endtask
  // frame of 16 or 12 bits with the write sequence marked valid
  task automatic t_write(input int tail);
    i_mst.sel();
    @(posedge mclk) write_armed <= 1'b1;
    i_mst.xfer(8'h02, 8, r);
    i_mst.xfer(8'h5a, tail, r);
    i_mst.desel();
  endtask
  task automatic t_full_write();
    t_write(8);
    wt(1'b0, 1'b1, 12);
    @(posedge mclk) write_armed <= 1'b0;
    @(negedge mclk);
    chk("standby", standby, 1'b0);
    i_mst.sel();
    chk("write_busy", write_busy, 1'b1);
    i_mst.desel();
    wt(1'b0, 1'b0, 80);
    repeat (3) @(negedge mclk);
    chk("standby", standby, 1'b1);
  endtask
  task automatic t_abandon();
    t_write(4);
    wt(1'b1, 1'b1, 12);
    @(posedge mclk) write_armed <= 1'b0;
    repeat (20) @(negedge mclk);
    chk("write_busy", write_busy, 1'b0);
    chk("standby", standby, 1'b1);
    // traffic while deselected after arming must leave no trace
    i_mst.xfer(8'hff, 8, r);
    chk("bit_count", bit_count, 16'h0000);
    chk("rx_byte", rx_byte, 8'h02);
  endtask
  // free-running system clock
  initial begin
    forever #50 mclk = ~mclk;
  end
  // reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_power_up();
    t_read();
    t_full_write();
    t_abandon();
    close_out();
  end
endmodule

// ==== write_timer.sv ====
`timescale 1ns/1ps

module write_timer #(
  parameter int TWC_CYCLES = spi_sel_pkg::TWC_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  write_timer_if.timer wt
);

  localparam int CW = $clog2(TWC_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TWC_CYCLES - 1);

  logic [CW-1:0] count_reg;
  logic busy_reg;
  logic done_reg;

  // once started the count ignores select entirely; only reset can stop it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg && wt.start) begin
        busy_reg <= 1'b1;
        count_reg <= '0;
      end else if (busy_reg) begin
        if (count_reg == LAST) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          count_reg <= count_reg + CW'(1);
        end
      end
    end
  end

  assign wt.busy = busy_reg;
  assign wt.done = done_reg;

endmodule

// ==== write_timer_if.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------------
// launch and progress of the self-timed write cycle
// ------------------------------------------------------------------
interface write_timer_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface
